// File: verilog/lane_select_defs.vh
// constants for the multiplier operand lane selector
`ifndef LANE_SELECT_DEFS_VH
`define LANE_SELECT_DEFS_VH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define LS_BUS_W        72
`define LS_RAMRD_W      144
`define LS_LANE_W       8
`define LS_BANK_LANES   8
`define LS_FIFO_DEPTH   8
`define LS_FIFO_AW      3

// ----------------------------------------------------------------
// lane-map codes
// ----------------------------------------------------------------
`define LS_MAP_I8_X1     6'h00
`define LS_MAP_I8_X2     6'h01
`define LS_MAP_I7_X1     6'h07
`define LS_MAP_I7_X2     6'h08
`define LS_MAP_I6_X1     6'h0a
`define LS_MAP_I8_SPLIT  6'h20
`define LS_MAP_I8_X4     6'h21
`define LS_MAP_I7_SPLIT  6'h27
`define LS_MAP_I7_X4     6'h28
`define LS_MAP_DEFAULT   6'h00

// ----------------------------------------------------------------
// lane widths, lane counts and field bases
// ----------------------------------------------------------------
`define LS_W8            4'h8
`define LS_W7            4'h7
`define LS_W6            4'h6
`define LS_N0            4'h0
`define LS_N2            4'h2
`define LS_N4            4'h4
`define LS_N5            4'h5
`define LS_N6            4'h6
`define LS_N8            4'h8
`define LS_BASE0         7'h00
`define LS_I8_B_BASE     7'h20
`define LS_I7_B_BASE     7'h23
`define LS_I6_B_BASE     7'h24
`define LS_I7_X2_H_BASE  7'h38

// ----------------------------------------------------------------
// operand source select codes (high bank numbering)
// ----------------------------------------------------------------
`define LS_SRC_DIN       3'h0
`define LS_SRC_RAM_WR    3'h1
`define LS_SRC_LRAM_LO   3'h2
`define LS_SRC_LRAM_HI   3'h3
`define LS_SRC_RAM_RD_LO 3'h4
`define LS_SRC_RAM_RD_HI 3'h5
`define LS_SRC_CASC_LO   3'h6
`define LS_SRC_CASC_HI   3'h7

`endif

// File: verilog/operand_fifo.v
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module operand_fifo #(
  parameter WIDTH = 72,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_core_clk,
  input  wire             i_rst_n,
  input  wire             i_ce,
  input  wire             i_wr_valid,
  output wire             o_wr_ready,
  input  wire [WIDTH-1:0] i_wr_data,
  output wire             o_rd_valid,
  input  wire             i_rd_ready,
  output wire [WIDTH-1:0] o_rd_data
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;
  integer         k;

  // full and empty come straight from the occupancy count
  assign o_wr_ready = (count_ff != DEPTH[AW:0]);
  assign o_rd_valid = (count_ff != {(AW+1){1'b0}});
  assign push       = i_ce & i_wr_valid & o_wr_ready;
  assign pop        = i_ce & i_rd_ready & o_rd_valid;
  assign o_rd_data  = mem_ff[rd_ptr_ff];

  // pointers and count; clock enable low freezes everything
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push & ~pop)
        count_ff <= count_ff + 1'b1;
      else if (pop & ~push)
        count_ff <= count_ff - 1'b1;
    end
  end

  // storage, indexed by the write pointer
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (k = 0; k < DEPTH; k = k + 1)
        mem_ff[k] <= {WIDTH{1'b0}};
    end else if (push) begin
      mem_ff[wr_ptr_ff] <= i_wr_data;
    end
  end
endmodule // operand_fifo

// File: verilog/operand_source_mux.v
// eight-way operand bus source selector
`timescale 1ns/1ps
`include "lane_select_defs.vh"
module operand_source_mux (
  input  wire [2:0]  i_sel,
  input  wire [71:0] i_din,
  input  wire [71:0] i_ram_wr,
  input  wire [71:0] i_lram_lo,
  input  wire [71:0] i_lram_hi,
  input  wire [71:0] i_ram_rd_lo,
  input  wire [71:0] i_ram_rd_hi,
  input  wire [71:0] i_casc_lo,
  input  wire [71:0] i_casc_hi,
  output reg  [71:0] o_bus
);
  // one source per code, full decode so no latch
  always @* begin
    case (i_sel)
      `LS_SRC_DIN:       o_bus = i_din;
      `LS_SRC_RAM_WR:    o_bus = i_ram_wr;
      `LS_SRC_LRAM_LO:   o_bus = i_lram_lo;
      `LS_SRC_LRAM_HI:   o_bus = i_lram_hi;
      `LS_SRC_RAM_RD_LO: o_bus = i_ram_rd_lo;
      `LS_SRC_RAM_RD_HI: o_bus = i_ram_rd_hi;
      `LS_SRC_CASC_LO:   o_bus = i_casc_lo;
      `LS_SRC_CASC_HI:   o_bus = i_casc_hi;
      default:           o_bus = i_din;
    endcase
  end
endmodule // operand_source_mux

// File: verilog/multiplier_operand_lane_select.v
// operand source selection and lane mapping for a sixteen-multiplier tile
//
// Contract
// - accept 72-bit ram write-data tap as source
// - accept 144-bit ram read-data tap as source
// - four 72-bit forward cascade inputs provided
// - drive four 72-bit forward cascade outputs
// - high b cascade ignores high direct route
// - low b cascade ignores low direct route
// - low map feeds 7-0, high 15-8
// - lane width follows selected number format
// - low and high lane maps are independent
// - low map may keep x1 in expansions
// - shared input: a low bits, b high
// - int8 x1: four multipliers, b at 63:32
// - int8 x2: eight multipliers from low buses
// - int8 x4: high buses feed 15-8
// - int8 split: high 8-11 mirror low 0-3
// - int7 x1: five 7-bit lanes, b 69:35
// - int7 x2: ten lanes, 8-9 high 69:56
// - int7 x4: high buses 55:0 feed 15-8
// - int7 split: five low, five high
// - int6 x1: six 6-bit lanes, b 71:36
// - low direct route feeds low b bank
// - high a select picks eight sources
`timescale 1ns/1ps
`include "lane_select_defs.vh"
module multiplier_operand_lane_select (
  input  wire          i_core_clk,
  input  wire          i_rst_n,
  input  wire          i_ce,
  // general data input stream
  input  wire          i_din_valid,
  output wire          o_din_ready,
  input  wire [71:0]   i_din,
  // dedicated ram paths and local ram
  input  wire [71:0]   i_ram_write_data_tap,
  input  wire [143:0]  i_ram_read_data_tap,
  input  wire [143:0]  i_local_ram_data,
  // forward cascade inputs
  input  wire [71:0]   i_fwd_a_high,
  input  wire [71:0]   i_fwd_b_high,
  input  wire [71:0]   i_fwd_a_low,
  input  wire [71:0]   i_fwd_b_low,
  // static configuration
  input  wire [2:0]    i_sel_a_high,
  input  wire [1:0]    i_sel_a_low,
  input  wire [2:0]    i_sel_b_high,
  input  wire [1:0]    i_sel_b_low,
  input  wire          i_local_ram_direct_b_high,
  input  wire          i_local_ram_direct_b_low,
  input  wire [4:0]    i_lane_map_low,
  input  wire [5:0]    i_lane_map_high,
  // lane outputs towards the multipliers
  output wire          o_lane_valid,
  input  wire          i_lane_ready,
  output wire [127:0]  o_lane_a,
  output wire [127:0]  o_lane_b,
  output wire [15:0]   o_lane_active,
  output wire [3:0]    o_lane_width_low,
  output wire [3:0]    o_lane_width_high,
  // forward cascade outputs
  output wire [71:0]   o_fwd_a_high,
  output wire [71:0]   o_fwd_b_high,
  output wire [71:0]   o_fwd_a_low,
  output wire [71:0]   o_fwd_b_low
);

  // ----------------------------------------------------------------
  // decode and lane helpers
  // ----------------------------------------------------------------

  // map code to {lane count, lane width, a base, b base}
  function [21:0] map_decode;
    input [5:0] code;
    input       high_bank;
    reg   [3:0] n;
    reg   [3:0] w;
    reg   [6:0] ab;
    reg   [6:0] bb;
    begin
      n  = `LS_N0;
      w  = `LS_W8;
      ab = `LS_BASE0;
      bb = `LS_BASE0;
      if (!high_bank) begin
        case (code)
          `LS_MAP_I8_X1: begin
            n  = `LS_N4;
            bb = `LS_I8_B_BASE;
          end
          `LS_MAP_I8_X2: begin
            n  = `LS_N8;
          end
          `LS_MAP_I7_X1: begin
            n  = `LS_N5;
            w  = `LS_W7;
            bb = `LS_I7_B_BASE;
          end
          `LS_MAP_I7_X2: begin
            n  = `LS_N8;
            w  = `LS_W7;
          end
          `LS_MAP_I6_X1: begin
            n  = `LS_N6;
            w  = `LS_W6;
            bb = `LS_I6_B_BASE;
          end
          default: n = `LS_N0;
        endcase
      end else begin
        case (code)
          `LS_MAP_I7_X2: begin
            n  = `LS_N2;
            w  = `LS_W7;
            ab = `LS_I7_X2_H_BASE;
            bb = `LS_I7_X2_H_BASE;
          end
          `LS_MAP_I8_SPLIT: begin
            n  = `LS_N4;
            bb = `LS_I8_B_BASE;
          end
          `LS_MAP_I8_X4: begin
            n  = `LS_N8;
          end
          `LS_MAP_I7_SPLIT: begin
            n  = `LS_N5;
            w  = `LS_W7;
            bb = `LS_I7_B_BASE;
          end
          `LS_MAP_I7_X4: begin
            n  = `LS_N8;
            w  = `LS_W7;
          end
          // x1 codes and the int8 x2 code leave the high buses unused
          default: n = `LS_N0;
        endcase
      end
      map_decode = {n, w, ab, bb};
    end
  endfunction

  // pull one lane of width w out of a bus, zero-extended to 8 bits
  function [7:0] lane_pick;
    input [71:0] bus;
    input [3:0]  w;
    input [6:0]  base;
    input [2:0]  idx;
    reg   [7:0]  sh;
    reg   [71:0] t;
    begin
      sh = {1'b0, base} + ({5'h00, idx} * {4'h0, w});
      t  = bus >> sh;
      case (w)
        `LS_W8:  lane_pick = t[7:0];
        `LS_W7:  lane_pick = {1'b0, t[6:0]};
        `LS_W6:  lane_pick = {2'b00, t[5:0]};
        default: lane_pick = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // data input buffer
  // ----------------------------------------------------------------
  wire        head_valid;
  wire        head_pop;
  wire [71:0] head_din;

  // din is buffered so a stalled consumer back-pressures the source
  operand_fifo #(
    .WIDTH (`LS_BUS_W),
    .DEPTH (`LS_FIFO_DEPTH),
    .AW    (`LS_FIFO_AW)
  ) u_din_fifo (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_wr_valid (i_din_valid),
    .o_wr_ready (o_din_ready),
    .i_wr_data  (i_din),
    .o_rd_valid (head_valid),
    .i_rd_ready (head_pop),
    .o_rd_data  (head_din)
  );

  // ----------------------------------------------------------------
  // operand bus source selection
  // ----------------------------------------------------------------
  wire [71:0] sel_a_high;
  wire [71:0] sel_b_high;
  wire [71:0] sel_a_low;
  wire [71:0] sel_b_low;
  wire [71:0] bus_b_high;
  wire [71:0] bus_b_low;

  // high a: full eight-source choice
  operand_source_mux u_mux_a_high (
    .i_sel       (i_sel_a_high),
    .i_din       (head_din),
    .i_ram_wr    (i_ram_write_data_tap),
    .i_lram_lo   (i_local_ram_data[71:0]),
    .i_lram_hi   (i_local_ram_data[143:72]),
    .i_ram_rd_lo (i_ram_read_data_tap[71:0]),
    .i_ram_rd_hi (i_ram_read_data_tap[143:72]),
    .i_casc_lo   (i_fwd_a_low),
    .i_casc_hi   (i_fwd_a_high),
    .o_bus       (sel_a_high)
  );

  // high b: same choice, b cascades
  operand_source_mux u_mux_b_high (
    .i_sel       (i_sel_b_high),
    .i_din       (head_din),
    .i_ram_wr    (i_ram_write_data_tap),
    .i_lram_lo   (i_local_ram_data[71:0]),
    .i_lram_hi   (i_local_ram_data[143:72]),
    .i_ram_rd_lo (i_ram_read_data_tap[71:0]),
    .i_ram_rd_hi (i_ram_read_data_tap[143:72]),
    .i_casc_lo   (i_fwd_b_low),
    .i_casc_hi   (i_fwd_b_high),
    .o_bus       (sel_b_high)
  );

  // low banks use the even codes: din, lram low, ram read low, cascade low
  operand_source_mux u_mux_a_low (
    .i_sel       ({i_sel_a_low, 1'b0}),
    .i_din       (head_din),
    .i_ram_wr    (i_ram_write_data_tap),
    .i_lram_lo   (i_local_ram_data[71:0]),
    .i_lram_hi   (i_local_ram_data[143:72]),
    .i_ram_rd_lo (i_ram_read_data_tap[71:0]),
    .i_ram_rd_hi (i_ram_read_data_tap[143:72]),
    .i_casc_lo   (i_fwd_a_low),
    .i_casc_hi   (i_fwd_a_high),
    .o_bus       (sel_a_low)
  );

  operand_source_mux u_mux_b_low (
    .i_sel       ({i_sel_b_low, 1'b0}),
    .i_din       (head_din),
    .i_ram_wr    (i_ram_write_data_tap),
    .i_lram_lo   (i_local_ram_data[71:0]),
    .i_lram_hi   (i_local_ram_data[143:72]),
    .i_ram_rd_lo (i_ram_read_data_tap[71:0]),
    .i_ram_rd_hi (i_ram_read_data_tap[143:72]),
    .i_casc_lo   (i_fwd_b_low),
    .i_casc_hi   (i_fwd_b_high),
    .o_bus       (sel_b_low)
  );

  // direct local ram routes replace only the multiplier b buses
  assign bus_b_low  = i_local_ram_direct_b_low ? i_local_ram_data[71:0]
                                               : sel_b_low;
  assign bus_b_high = i_local_ram_direct_b_high ? i_local_ram_data[143:72]
                                                : sel_b_high;

  // ----------------------------------------------------------------
  // lane mapping, one decode per bank
  // ----------------------------------------------------------------
  wire [21:0]  dec_low;
  wire [21:0]  dec_high;
  wire [127:0] nxt_lane_a;
  wire [127:0] nxt_lane_b;
  wire [15:0]  nxt_active;

  // each bank decodes its own map; nothing ties the two together
  assign dec_low  = map_decode({1'b0, i_lane_map_low}, 1'b0);
  assign dec_high = map_decode(i_lane_map_high, 1'b1);

  genvar g;
  generate
    for (g = 0; g < `LS_BANK_LANES; g = g + 1) begin : g_lane
      localparam integer GI  = g;
      localparam [2:0]   IDX = GI[2:0];
      wire use_low;
      wire use_high;

      // lanes beyond the mode's count read as zero whatever the bus holds
      assign use_low  = ({1'b0, IDX} < dec_low[21:18]);
      assign use_high = ({1'b0, IDX} < dec_high[21:18]);
      assign nxt_active[g]   = use_low;
      assign nxt_active[g+8] = use_high;

      // low bank: multipliers 7-0 from the low buses
      assign nxt_lane_a[8*g +: 8] = use_low ?
        lane_pick(sel_a_low, dec_low[17:14], dec_low[13:7], IDX) : 8'h00;
      assign nxt_lane_b[8*g +: 8] = use_low ?
        lane_pick(bus_b_low, dec_low[17:14], dec_low[6:0], IDX) : 8'h00;

      // high bank: multipliers 15-8 from the high buses
      assign nxt_lane_a[8*g+64 +: 8] = use_high ?
        lane_pick(sel_a_high, dec_high[17:14], dec_high[13:7], IDX) : 8'h00;
      assign nxt_lane_b[8*g+64 +: 8] = use_high ?
        lane_pick(bus_b_high, dec_high[17:14], dec_high[6:0], IDX) : 8'h00;
    end
  endgenerate

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  reg          out_valid_ff;
  reg  [127:0] lane_a_ff;
  reg  [127:0] lane_b_ff;
  reg  [15:0]  active_ff;
  reg  [3:0]   width_low_ff;
  reg  [3:0]   width_high_ff;
  reg  [71:0]  fwd_a_high_ff;
  reg  [71:0]  fwd_b_high_ff;
  reg  [71:0]  fwd_a_low_ff;
  reg  [71:0]  fwd_b_low_ff;
  wire         load;

  // take a new word when the holding stage is empty or being drained
  assign load     = i_ce & head_valid & (~out_valid_ff | i_lane_ready);
  assign head_pop = ~out_valid_ff | i_lane_ready;

  // lanes and cascades are captured together; routing itself is
  // combinational from static settings, the flops only time the data
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_valid_ff  <= 1'b0;
      lane_a_ff     <= 128'h0;
      lane_b_ff     <= 128'h0;
      active_ff     <= 16'h0000;
      width_low_ff  <= 4'h0;
      width_high_ff <= 4'h0;
      fwd_a_high_ff <= 72'h0;
      fwd_b_high_ff <= 72'h0;
      fwd_a_low_ff  <= 72'h0;
      fwd_b_low_ff  <= 72'h0;
    end else if (i_ce) begin
      if (load) begin
        out_valid_ff  <= 1'b1;
        lane_a_ff     <= nxt_lane_a;
        lane_b_ff     <= nxt_lane_b;
        active_ff     <= nxt_active;
        width_low_ff  <= dec_low[17:14];
        width_high_ff <= dec_high[17:14];
        fwd_a_high_ff <= sel_a_high;
        fwd_b_high_ff <= sel_b_high;
        fwd_a_low_ff  <= sel_a_low;
        fwd_b_low_ff  <= sel_b_low;
      end else if (i_lane_ready) begin
        out_valid_ff  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // output wiring
  // ----------------------------------------------------------------
  assign o_lane_valid      = out_valid_ff;
  assign o_lane_a          = lane_a_ff;
  assign o_lane_b          = lane_b_ff;
  assign o_lane_active     = active_ff;
  assign o_lane_width_low  = width_low_ff;
  assign o_lane_width_high = width_high_ff;
  assign o_fwd_a_high      = fwd_a_high_ff;
  assign o_fwd_b_high      = fwd_b_high_ff;
  assign o_fwd_a_low       = fwd_a_low_ff;
  assign o_fwd_b_low       = fwd_b_low_ff;

endmodule // multiplier_operand_lane_select

// File: sim/lane_select_checker_properties.sv
// port-level assertions for the operand lane selector
`timescale 1ns/1ps
module lane_select_checker (
  input wire         i_core_clk,
  input wire         i_rst_n,
  input wire         i_ce,
  input wire         i_din_valid,
  input wire         o_din_ready,
  input wire         o_lane_valid,
  input wire         i_lane_ready,
  input wire [4:0]   i_lane_map_low,
  input wire [5:0]   i_lane_map_high,
  input wire [127:0] o_lane_a,
  input wire [127:0] o_lane_b,
  input wire [15:0]  o_lane_active,
  input wire [3:0]   o_lane_width_low,
  input wire [3:0]   o_lane_width_high,
  input wire [71:0]  o_fwd_b_low
);
  // single clock domain, so one default clocking
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // short aliases; maps are static while a word stands
  wire        v   = o_lane_valid;
  wire [4:0]  lo  = i_lane_map_low;
  wire [5:0]  hi  = i_lane_map_high;
  wire [15:0] act = o_lane_active;
  wire [3:0]  wl  = o_lane_width_low;
  wire [3:0]  wh  = o_lane_width_high;
  // ----------------------------------------------------------------
  // lane sets per map, then idle lanes, first-word latency and stall hold
  // ----------------------------------------------------------------
  AST_I8_X1:
    assert property (v && lo == 5'h00 && hi == 6'h00 |-> act == 16'h000f && wl == 4'h8)
    else $error("int8 x1 lane set wrong");
  AST_I8_X4:
    assert property (v && lo == 5'h01 && hi == 6'h21 |-> act == 16'hffff)
    else $error("int8 x4 lane set wrong");
  AST_LOW_X2:
    assert property (v && lo == 5'h01 |-> act[7:0] == 8'hff)
    else $error("low x2 lanes depend on high map");
  AST_I7_SPLIT:
    assert property (v && lo == 5'h07 && hi == 6'h27 |-> act == 16'h1f1f && wl == 4'h7 && wh == 4'h7)
    else $error("int7 split lane set wrong");
  AST_I6_X1:
    assert property (v && lo == 5'h0a |-> act[7:0] == 8'h3f && wl == 4'h6)
    else $error("int6 x1 low lanes wrong");
  AST_IDLE_LANE_ZERO:
    assert property (v && !act[15] |-> o_lane_a[127:120] == 8'h00 && o_lane_b[127:120] == 8'h00)
    else $error("unfed lane not zero");
  AST_FIRST_WORD:
    assert property (i_ce && i_din_valid && o_din_ready && !v |-> ##[1:2] v)
    else $error("first word late");
  AST_STALL_HOLDS:
    assert property (v && !i_lane_ready |=> v && $stable(o_lane_a) && $stable(o_fwd_b_low))
    else $error("stalled word changed");
endmodule // lane_select_checker

bind multiplier_operand_lane_select lane_select_checker u_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_din_valid(i_din_valid), .o_din_ready(o_din_ready),
  .o_lane_valid(o_lane_valid), .i_lane_ready(i_lane_ready),
  .i_lane_map_low(i_lane_map_low), .i_lane_map_high(i_lane_map_high),
  .o_lane_a(o_lane_a), .o_lane_b(o_lane_b), .o_lane_active(o_lane_active),
  .o_lane_width_low(o_lane_width_low), .o_lane_width_high(o_lane_width_high),
  .o_fwd_b_low(o_fwd_b_low)
);

// File: sim/far_side_model.sv
// far-side model: paired ram, neighbour cascades and lane consumer
`timescale 1ns/1ps
module far_side_model (
  input  wire         i_core_clk,
  input  wire         i_rst_n,
  input  wire [1:0]   i_pace,
  input  wire [71:0]  i_pat,
  output wire [71:0]  o_ram_wr,
  output wire [143:0] o_ram_rd,
  output wire [143:0] o_lram,
  output wire [287:0] o_fwd,
  output reg          o_ready
);
  // rotations keep every source distinct, so a wrong pick shows
  function [71:0] rot(input [71:0] p, input integer n);
    rot = (p << n) | (p >> (72 - n));
  endfunction
  // ram paths come only from this paired ram, never from the bench
  assign o_ram_wr = ~i_pat;
  assign o_ram_rd = {rot(i_pat, 8), rot(i_pat, 16)};
  assign o_lram   = {rot(i_pat, 24), rot(i_pat, 32)};
  assign o_fwd    = {rot(i_pat, 40), rot(i_pat, 48), rot(i_pat, 56), rot(i_pat, 64)};
  // consumer pace: 0 prompt, 1 every other cycle, 2 stopped
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_ready <= 1'b0;
    else
      o_ready <= (i_pace == 2'h0) | ((i_pace == 2'h1) & ~o_ready);
  end
endmodule // far_side_model

// File: sim/tb_top.sv
// self-checking bench for the multiplier operand lane selector
`timescale 1ns/1ps
module tb_top;
  reg          clk = 1'b0;
  reg          rst_n = 1'b0;
  reg          ce = 1'b1;
  reg          din_valid = 1'b0;
  reg  [71:0]  din = 72'h0;
  reg  [71:0]  pat = 72'h3c_96e1_5a2d_7b48_f01e;
  reg  [1:0]   pace = 2'h0;
  reg  [2:0]   s_ah = 3'h0;
  reg  [2:0]   s_bh = 3'h0;
  reg  [1:0]   s_al = 2'h0;
  reg  [1:0]   s_bl = 2'h0;
  reg          dir_h = 1'b0;
  reg          dir_l = 1'b0;
  reg  [4:0]   map_l = 5'h0;
  reg  [5:0]   map_h = 6'h0;
  wire         din_rdy, l_valid, l_rdy;
  wire [71:0]  ram_wr, fah, fbh, fal, fbl;
  wire [143:0] ram_rd, lram;
  wire [287:0] fwd;
  wire [127:0] la, lb;
  wire [15:0]  act;
  wire [3:0]   wl, wh;
  integer      n_fail = 0;
  integer      total_checks = 0;
  integer      cyc = 0;

  always #12.5 clk = ~clk;

  multiplier_operand_lane_select dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_din_valid(din_valid), .o_din_ready(din_rdy), .i_din(din),
    .i_ram_write_data_tap(ram_wr), .i_ram_read_data_tap(ram_rd),
    .i_local_ram_data(lram), .i_fwd_a_high(fwd[71:0]), .i_fwd_b_high(fwd[143:72]),
    .i_fwd_a_low(fwd[215:144]), .i_fwd_b_low(fwd[287:216]),
    .i_sel_a_high(s_ah), .i_sel_a_low(s_al), .i_sel_b_high(s_bh), .i_sel_b_low(s_bl),
    .i_local_ram_direct_b_high(dir_h), .i_local_ram_direct_b_low(dir_l),
    .i_lane_map_low(map_l), .i_lane_map_high(map_h),
    .o_lane_valid(l_valid), .i_lane_ready(l_rdy), .o_lane_a(la), .o_lane_b(lb),
    .o_lane_active(act), .o_lane_width_low(wl), .o_lane_width_high(wh),
    .o_fwd_a_high(fah), .o_fwd_b_high(fbh), .o_fwd_a_low(fal), .o_fwd_b_low(fbl)
  );
  far_side_model partner (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_pace(pace), .i_pat(pat),
    .o_ram_wr(ram_wr), .o_ram_rd(ram_rd), .o_lram(lram), .o_fwd(fwd), .o_ready(l_rdy)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input [127:0] seen, input [127:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // lane field, zero-extended to the 8-bit output slot
  function [7:0] fld(input [71:0] b, input integer p, input integer w);
    fld = (b >> p) & ((72'h1 << w) - 72'h1);
  endfunction
  // expected bus for a high-bank select code
  function [71:0] src(input [2:0] c, input b);
    case (c)
      3'h0: src = din;
      3'h1: src = ram_wr;
      3'h2: src = lram[71:0];
      3'h3: src = lram[143:72];
      3'h4: src = ram_rd[71:0];
      3'h5: src = ram_rd[143:72];
      3'h6: src = b ? fwd[287:216] : fwd[215:144];
      default: src = b ? fwd[143:72] : fwd[71:0];
    endcase
  endfunction
  // offer one word at a falling edge, then wait for it at the lanes
  task xfer(input [71:0] d);
    integer k;
    begin
      din = d;
      din_valid = 1'b1;
      k = 0;
      while (din_rdy !== 1'b1 && k < 50) begin
        @(negedge clk);
        k = k + 1;
      end
      @(negedge clk);
      din_valid = 1'b0;
      while (l_valid !== 1'b1 && k < 50) begin
        @(negedge clk);
        k = k + 1;
      end
      check(l_valid, 1'b1);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // each map pairing; row = maps, lanes, widths, then the a lane and b lane checked with their bus offsets
  task t_modes;
    reg [63:0] r;
    integer    i, ka, kb;
    begin
      s_bl = 2'h1;
      s_ah = 3'h1;
      s_bh = 3'h5;
      for (i = 0; i < 9; i = i + 1) begin
        case (i)
          0: r = 64'h00_00_000f_88_3_18_3_38;
          1: r = 64'h01_01_00ff_88_7_38_7_38;
          2: r = 64'h01_21_ffff_88_f_38_f_38;
          3: r = 64'h00_20_0f0f_88_b_18_b_38;
          4: r = 64'h07_07_001f_78_4_1c_4_3f;
          5: r = 64'h08_08_03ff_77_9_3f_8_38;
          6: r = 64'h08_28_ffff_77_f_31_f_31;
          7: r = 64'h07_27_1f1f_77_c_1c_c_3f;
          default: r = 64'h0a_0a_003f_68_5_1e_5_42;
        endcase
        @(negedge clk);
        map_l = r[60:56];
        map_h = r[53:48];
        xfer(72'ha5_0123_4567_89ab_cdef);
        ka = r[23:20];
        kb = r[11:8];
        check({act, wl, wh}, r[47:24]);
        check(la[ka*8 +: 8], fld(ka < 8 ? din : ram_wr, r[19:12], ka < 8 ? r[31:28] : r[27:24]));
        check(lb[kb*8 +: 8], fld(kb < 8 ? lram[71:0] : ram_rd[143:72], r[7:0], kb < 8 ? r[31:28] : r[27:24]));
      end
    end
  endtask
  // one input feeds both low buses; its spare top byte must not leak
  task t_shared;
    begin
      @(negedge clk);
      s_bl = 2'h0;
      map_l = 5'h00;
      map_h = 6'h00;
      xfer(72'hff_8765_4321_1234_5678);
      check(la, {96'h0, din[31:0]});
      check(lb, {96'h0, din[63:32]});
    end
  endtask
  // all select codes with the direct routes toggled underneath
  task t_select;
    reg [71:0] e;
    integer    i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(negedge clk);
        map_l = 5'h01;
        map_h = 6'h21;
        s_ah = i[2:0];
        s_bh = i[2:0];
        s_al = i[1:0];
        s_bl = i[1:0];
        dir_l = i[1];
        dir_h = i[0];
        xfer(72'h5a_f00d_1234_abcd_0f0f);
        check(fah, src(i[2:0], 1'b0));
        check(fbh, src(i[2:0], 1'b1));
        check(fal, src({i[1:0], 1'b0}, 1'b0));
        check(fbl, src({i[1:0], 1'b0}, 1'b1));
        e = dir_l ? lram[71:0] : src({i[1:0], 1'b0}, 1'b1);
        check(lb[7:0], e[7:0]);
        e = dir_h ? lram[143:72] : src(i[2:0], 1'b1);
        check(lb[71:64], e[7:0]);
      end
    end
  endtask
  // fill against a stopped consumer, then drain it at half pace
  task t_fifo;
    integer n, j, k;
    begin
      @(negedge clk);
      pace = 2'h2;
      s_al = 2'h0;
      n = 0;
      while (din_rdy === 1'b1 && n < 12) begin
        din = n;
        din_valid = 1'b1;
        @(negedge clk);
        n = n + 1;
      end
      din_valid = 1'b0;
      check(n, 9);
      // enable low must freeze fifo and output word although ready toggles
      ce = 1'b0;
      pace = 2'h1;
      repeat (3) @(negedge clk);
      check({l_valid, din_rdy, la[7:0]}, 10'h200);
      ce = 1'b1;
      for (j = 0; j < n; j = j + 1) begin
        k = 0;
        while ((l_valid & l_rdy) !== 1'b1 && k < 20) begin
          @(negedge clk);
          k = k + 1;
        end
        check(la[7:0], j[7:0]);
        @(negedge clk);
      end
      check({l_valid, din_rdy}, 2'b01);
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end

  initial begin
    repeat (10) @(negedge clk);
    check({l_valid, din_rdy, la[7:0]}, 10'h100);
    rst_n = 1'b1;
    t_modes;
    t_shared;
    t_select;
    t_fifo;
    print_verdict;
  end
endmodule // tb_top
